// ===== rtl/dmod_cfg.svh
// Register offsets, field positions and reset values of the modulator
`ifndef DMOD_CFG_SVH
`define DMOD_CFG_SVH

`define DMOD_ADDR_W        12
`define DMOD_ADDR_CON0     12'h897
`define DMOD_ADDR_CON1     12'h898
`define DMOD_ADDR_SRC      12'h899
`define DMOD_ADDR_LCAR     12'h89a
`define DMOD_ADDR_HCAR     12'h89b

`define DMOD_EN_POS        7
`define DMOD_OUT_POS       5
`define DMOD_OINV_POS      4
`define DMOD_SWMOD_POS     0
`define DMOD_HINV_POS      5
`define DMOD_HSYNC_POS     4
`define DMOD_LINV_POS      1
`define DMOD_LSYNC_POS     0

`define DMOD_RST_CON0      8'h00
`define DMOD_RST_CON1      8'h00
`define DMOD_RST_SRC       5'h00
`define DMOD_RST_LCAR      4'h0
`define DMOD_RST_HCAR      4'h0

`define DMOD_SRC_RSVD_LO   5'h14
`define DMOD_SYNC_W        5

`endif

// ===== rtl/dmod_pkg.sv
// Types shared by the modulator modules
package dmod_pkg;

  typedef logic [4:0] dmod_src_code_t;
  typedef logic [3:0] dmod_car_code_t;

  typedef enum logic [4:0] {
    DMOD_SRC_PIN   = 5'h00,
    DMOD_SRC_SW    = 5'h01,
    DMOD_SRC_CCP1  = 5'h02,
    DMOD_SRC_CCP2  = 5'h03,
    DMOD_SRC_CCP3  = 5'h04,
    DMOD_SRC_CCP4  = 5'h05,
    DMOD_SRC_PWM1  = 5'h06,
    DMOD_SRC_PWM2  = 5'h07,
    DMOD_SRC_NOSC  = 5'h08,
    DMOD_SRC_CMP1  = 5'h09,
    DMOD_SRC_CMP2  = 5'h0a,
    DMOD_SRC_LC1   = 5'h0b,
    DMOD_SRC_LC2   = 5'h0c,
    DMOD_SRC_LC3   = 5'h0d,
    DMOD_SRC_LC4   = 5'h0e,
    DMOD_SRC_SER1  = 5'h0f,
    DMOD_SRC_SPI1  = 5'h10,
    DMOD_SRC_SPI2  = 5'h11,
    DMOD_SRC_CCP5  = 5'h12,
    DMOD_SRC_SER2  = 5'h13
  } dmod_src_t;

  typedef enum logic [3:0] {
    DMOD_ST_LOW   = 4'h1,
    DMOD_ST_HIGH  = 4'h2,
    DMOD_ST_HWAIT = 4'h4,
    DMOD_ST_LWAIT = 4'h8
  } dmod_state_t;

endpackage

// ===== rtl/dmod_car_if.sv
// Carrier selection bundle between the top and a carrier multiplexer
`timescale 1ns/10ps
`default_nettype none
interface dmod_car_if;
  logic [3:0]  code;
  logic        invert;
  logic [15:0] sources;
  logic        carrier;
  modport ctrl (output code, output invert, output sources, input carrier);
  modport mux  (input code, input invert, input sources, output carrier);
endinterface // dmod_car_if
`default_nettype wire

// ===== rtl/dmod_sync.sv
// Two-flop synchronisers for pin and foreign-clock inputs
`timescale 1ns/10ps
`default_nettype none
module dmod_sync #(
  parameter int W = 5
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          meta_r[i] <= 1'b0;
          q[i]      <= 1'b0;
        end else begin
          meta_r[i] <= d[i];
          q[i]      <= meta_r[i];
        end
      end
    end
  endgenerate
endmodule // dmod_sync
`default_nettype wire

// ===== rtl/dmod_car_mux.sv
// One carrier selector with polarity control
`timescale 1ns/10ps
`default_nettype none
module dmod_car_mux
  import dmod_pkg::*;
(
  // Carrier bundle
  dmod_car_if.mux cif
);
  // Same code map for both carriers; inversion ahead of the mixer
  always_comb begin
    cif.carrier = cif.sources[cif.code] ^ cif.invert;
  end
endmodule // dmod_car_mux
`default_nettype wire

// ===== rtl/dmod_top.sv
// Data signal modulator: registers, source select, carrier sync, output
`include "dmod_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module dmod_top
  import dmod_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Pin routes and foreign clocks
  input  wire logic        modulator_pin_route,
  input  wire logic        low_carrier_pin_route,
  input  wire logic        high_carrier_pin_route,
  input  wire logic        fast_internal_oscillator,
  input  wire logic        reference_clock_output,
  // Peripheral outputs on clk
  input  wire logic [4:0]  ccp_out,
  input  wire logic [1:0]  pwm_out,
  input  wire logic        numeric_oscillator_out,
  input  wire logic [1:0]  comparator_out,
  input  wire logic [3:0]  logic_cell_out,
  input  wire logic        serial_one_tx,
  input  wire logic [1:0]  spi_data_out,
  input  wire logic        serial_port_two_tx,
  // Modulated output
  output logic             modulated_out
);

  // Control state
  logic           enable_r;
  logic           output_invert_r;
  logic           software_modulation_input_r;
  logic           high_carrier_invert_r;
  logic           high_carrier_sync_enable_r;
  logic           low_carrier_invert_r;
  logic           low_carrier_sync_enable_r;
  dmod_src_code_t modulator_source_code_r;
  dmod_car_code_t low_carrier_code_r;
  dmod_car_code_t high_carrier_code_r;

  logic [7:0]     reg_rdata_r;
  logic           out_lvl_r;
  logic           sysclk_div_r;
  logic           hcar_prev_r;
  logic           lcar_prev_r;
  dmod_state_t    st_r;
  dmod_state_t    st_nxt;

  logic [`DMOD_SYNC_W-1:0] pins_async;
  logic [`DMOD_SYNC_W-1:0] pins_sync;
  logic           modulator_signal;
  logic           high_carrier;
  logic           low_carrier;
  logic           hcar_fall;
  logic           lcar_fall;
  logic           use_high;
  logic           mixed;

  assign reg_rdata     = reg_rdata_r;
  assign modulated_out = out_lvl_r;

  // Pins and foreign clocks are asynchronous to clk
  assign pins_async = {reference_clock_output, fast_internal_oscillator,
                       high_carrier_pin_route, low_carrier_pin_route,
                       modulator_pin_route};

  dmod_sync #(
    .W (`DMOD_SYNC_W)
  ) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    (pins_async),
    .q    (pins_sync)
  );

  // Register writes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      enable_r                    <= 1'(`DMOD_RST_CON0 >> `DMOD_EN_POS);
      output_invert_r             <= 1'b0;
      software_modulation_input_r <= 1'b0;
      high_carrier_invert_r       <= 1'b0;
      high_carrier_sync_enable_r  <= 1'b0;
      low_carrier_invert_r        <= 1'b0;
      low_carrier_sync_enable_r   <= 1'b0;
      modulator_source_code_r     <= `DMOD_RST_SRC;
      low_carrier_code_r          <= `DMOD_RST_LCAR;
      high_carrier_code_r         <= `DMOD_RST_HCAR;
    end else if (reg_wr) begin
      // Status bit of control 0 is not writable
      if (reg_addr == `DMOD_ADDR_CON0) begin
        enable_r                    <= reg_wdata[`DMOD_EN_POS];
        output_invert_r             <= reg_wdata[`DMOD_OINV_POS];
        software_modulation_input_r <= reg_wdata[`DMOD_SWMOD_POS];
      end else if (reg_addr == `DMOD_ADDR_CON1) begin
        high_carrier_invert_r       <= reg_wdata[`DMOD_HINV_POS];
        high_carrier_sync_enable_r  <= reg_wdata[`DMOD_HSYNC_POS];
        low_carrier_invert_r        <= reg_wdata[`DMOD_LINV_POS];
        low_carrier_sync_enable_r   <= reg_wdata[`DMOD_LSYNC_POS];
      end else if (reg_addr == `DMOD_ADDR_SRC) begin
        modulator_source_code_r     <= reg_wdata[4:0];
      end else if (reg_addr == `DMOD_ADDR_LCAR) begin
        low_carrier_code_r          <= reg_wdata[3:0];
      end else if (reg_addr == `DMOD_ADDR_HCAR) begin
        high_carrier_code_r         <= reg_wdata[3:0];
      end
    end
  end

  // Register reads: data valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_r <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_addr == `DMOD_ADDR_CON0) begin
      reg_rdata_r <= {enable_r, 1'b0, out_lvl_r, output_invert_r,
                      3'h0, software_modulation_input_r};
    end else if (reg_addr == `DMOD_ADDR_CON1) begin
      reg_rdata_r <= {2'h0, high_carrier_invert_r,
                      high_carrier_sync_enable_r, 2'h0,
                      low_carrier_invert_r, low_carrier_sync_enable_r};
    end else if (reg_addr == `DMOD_ADDR_SRC) begin
      reg_rdata_r <= {3'h0, modulator_source_code_r};
    end else if (reg_addr == `DMOD_ADDR_LCAR) begin
      reg_rdata_r <= {4'h0, low_carrier_code_r};
    end else if (reg_addr == `DMOD_ADDR_HCAR) begin
      reg_rdata_r <= {4'h0, high_carrier_code_r};
    end else begin
      reg_rdata_r <= 8'h00;
    end
  end

  // System clock as a carrier: clk/2 is the fastest level clk can show
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sysclk_div_r <= 1'b0;
    end else begin
      sysclk_div_r <= ~sysclk_div_r;
    end
  end

  // Modulator source multiplexer; reserved codes give a low modulator
  always_comb begin
    case (modulator_source_code_r)
      DMOD_SRC_PIN:  modulator_signal = pins_sync[0];
      DMOD_SRC_SW:   modulator_signal = software_modulation_input_r;
      DMOD_SRC_CCP1: modulator_signal = ccp_out[0];
      DMOD_SRC_CCP2: modulator_signal = ccp_out[1];
      DMOD_SRC_CCP3: modulator_signal = ccp_out[2];
      DMOD_SRC_CCP4: modulator_signal = ccp_out[3];
      DMOD_SRC_PWM1: modulator_signal = pwm_out[0];
      DMOD_SRC_PWM2: modulator_signal = pwm_out[1];
      DMOD_SRC_NOSC: modulator_signal = numeric_oscillator_out;
      DMOD_SRC_CMP1: modulator_signal = comparator_out[0];
      DMOD_SRC_CMP2: modulator_signal = comparator_out[1];
      DMOD_SRC_LC1:  modulator_signal = logic_cell_out[0];
      DMOD_SRC_LC2:  modulator_signal = logic_cell_out[1];
      DMOD_SRC_LC3:  modulator_signal = logic_cell_out[2];
      DMOD_SRC_LC4:  modulator_signal = logic_cell_out[3];
      DMOD_SRC_SER1: modulator_signal = serial_one_tx;
      DMOD_SRC_SPI1: modulator_signal = spi_data_out[0];
      DMOD_SRC_SPI2: modulator_signal = spi_data_out[1];
      DMOD_SRC_CCP5: modulator_signal = ccp_out[4];
      DMOD_SRC_SER2: modulator_signal = serial_port_two_tx;
      default:       modulator_signal = 1'b0;
    endcase
  end

  // Carrier multiplexers share one code map; only code 0 differs
  dmod_car_if car_l ();
  dmod_car_if car_h ();

  assign car_l.code    = low_carrier_code_r;
  assign car_l.invert  = low_carrier_invert_r;
  assign car_l.sources = {ccp_out[4], logic_cell_out, numeric_oscillator_out,
                          pwm_out, ccp_out[3:0], pins_sync[4],
                          pins_sync[3], sysclk_div_r,
                          pins_sync[1]};
  assign car_h.code    = high_carrier_code_r;
  assign car_h.invert  = high_carrier_invert_r;
  assign car_h.sources = {car_l.sources[15:1], pins_sync[2]};

  dmod_car_mux u_car_l (
    .cif (car_l.mux)
  );

  dmod_car_mux u_car_h (
    .cif (car_h.mux)
  );

  assign low_carrier  = car_l.carrier;
  assign high_carrier = car_h.carrier;

  // Carrier falling edges, seen after polarity
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hcar_prev_r <= 1'b0;
      lcar_prev_r <= 1'b0;
    end else begin
      hcar_prev_r <= high_carrier;
      lcar_prev_r <= low_carrier;
    end
  end

  assign hcar_fall = hcar_prev_r & ~high_carrier;
  assign lcar_fall = lcar_prev_r & ~low_carrier;

  // Carrier switch sequencer
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      DMOD_ST_LOW: begin
        if (modulator_signal) begin
          if (low_carrier_sync_enable_r) begin
            st_nxt = DMOD_ST_LWAIT;
          end else begin
            st_nxt = DMOD_ST_HIGH;
          end
        end
      end
      DMOD_ST_LWAIT: begin
        // Modulator dropping back cancels the pending switch
        if (!modulator_signal) begin
          st_nxt = DMOD_ST_LOW;
        end else if (lcar_fall) begin
          st_nxt = DMOD_ST_HIGH;
        end
      end
      DMOD_ST_HIGH: begin
        if (!modulator_signal) begin
          if (high_carrier_sync_enable_r) begin
            st_nxt = DMOD_ST_HWAIT;
          end else begin
            st_nxt = DMOD_ST_LOW;
          end
        end
      end
      DMOD_ST_HWAIT: begin
        if (modulator_signal) begin
          st_nxt = DMOD_ST_HIGH;
        end else if (hcar_fall) begin
          st_nxt = DMOD_ST_LOW;
        end
      end
      default: begin
        st_nxt = DMOD_ST_LOW;
      end
    endcase
  end

  // Sequencer keeps running while disabled so selections stay coherent
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= DMOD_ST_LOW;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Unsynchronised switching may narrow pulses; that is the user's choice
  assign use_high = (st_r == DMOD_ST_HIGH) || (st_r == DMOD_ST_HWAIT);
  assign mixed    = use_high ? high_carrier : low_carrier;

  // Output flop; clk sampling is the price of a glitch-free pin
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_lvl_r <= 1'b0;
    end else if (!enable_r) begin
      out_lvl_r <= 1'b0;
    end else begin
      out_lvl_r <= mixed ^ output_invert_r;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  out_held_low_a: assert property (
    !enable_r |=> !out_lvl_r
  ) else $error("output not low while disabled");

  status_bit_a: assert property (
    reg_rd && reg_addr == `DMOD_ADDR_CON0
      |=> reg_rdata[`DMOD_OUT_POS] == $past(out_lvl_r)
  ) else $error("status bit differs from output");

  out_polarity_a: assert property (
    enable_r |=> out_lvl_r == ($past(mixed) ^ $past(output_invert_r))
  ) else $error("output polarity wrong");

  sw_modulation_a: assert property (
    modulator_source_code_r == DMOD_SRC_SW
      |-> modulator_signal == software_modulation_input_r
  ) else $error("software bit not used as modulator");

  high_invert_a: assert property (
    high_carrier_code_r == 4'h1
      |-> high_carrier == (sysclk_div_r ^ high_carrier_invert_r)
  ) else $error("high carrier polarity wrong");

  low_invert_a: assert property (
    !low_carrier_invert_r && low_carrier_code_r == 4'h4
      |-> low_carrier == ccp_out[0]
  ) else $error("low carrier polarity wrong");

  high_sync_a: assert property (
    st_r == DMOD_ST_HIGH && !modulator_signal
      |=> st_r == ($past(high_carrier_sync_enable_r) ? DMOD_ST_HWAIT
                                                     : DMOD_ST_LOW)
  ) else $error("high carrier switch wrong");

  high_wait_a: assert property (
    st_r == DMOD_ST_HWAIT && !modulator_signal && !hcar_fall
      |=> use_high
  ) else $error("high carrier dropped before fall");

  low_sync_a: assert property (
    st_r == DMOD_ST_LOW && modulator_signal
      |=> st_r == ($past(low_carrier_sync_enable_r) ? DMOD_ST_LWAIT
                                                    : DMOD_ST_HIGH)
  ) else $error("low carrier switch wrong");

  reserved_src_a: assert property (
    modulator_source_code_r >= `DMOD_SRC_RSVD_LO |-> !modulator_signal
  ) else $error("reserved source not low");

  ccp_src_a: assert property (
    modulator_source_code_r == DMOD_SRC_CCP5
      |-> modulator_signal == ccp_out[4]
  ) else $error("source map wrong");

  hsync_cover_c: cover property (
    st_r == DMOD_ST_HWAIT ##1 st_r == DMOD_ST_LOW
  );
  lsync_cover_c: cover property (
    st_r == DMOD_ST_LWAIT ##1 st_r == DMOD_ST_HIGH
  );
  out_high_c: cover property (
    enable_r && !output_invert_r ##1 out_lvl_r
  );

endmodule // dmod_top
`default_nettype wire

// ===== testbench/dmod_src_model.sv
// Behavioural model of the peripherals, pins and clocks feeding the modulator
`timescale 1ns/10ps
`default_nettype none
module dmod_src_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Levels and toggle enables, bit i is modulator source code i,
  // bits 20..23 are low pin, high pin, fast oscillator, reference clock
  input  wire logic [23:0] lvl,
  input  wire logic [23:0] tog,
  // Pin routes and foreign clocks
  output logic             modulator_pin_route,
  output logic             low_carrier_pin_route,
  output logic             high_carrier_pin_route,
  output logic             fast_internal_oscillator,
  output logic             reference_clock_output,
  // Peripheral outputs
  output logic [4:0]       ccp_out,
  output logic [1:0]       pwm_out,
  output logic             numeric_oscillator_out,
  output logic [1:0]       comparator_out,
  output logic [3:0]       logic_cell_out,
  output logic             serial_one_tx,
  output logic [1:0]       spi_data_out,
  output logic             serial_port_two_tx
);
  logic [3:0]  cnt_r;
  logic [23:0] src;

  // Eight cycles high, eight low: slow enough to place a switch mid-pulse
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  assign src = lvl ^ (tog & {24{cnt_r[3]}});
  // Foreign-domain lines move away from the clock edge, as real pins do
  assign #3 modulator_pin_route = src[0];
  assign #3 low_carrier_pin_route = src[20];
  assign #3 high_carrier_pin_route = src[21];
  assign #3 fast_internal_oscillator = src[22];
  assign #3 reference_clock_output = src[23];
  assign ccp_out = {src[18], src[5:2]};
  assign pwm_out = src[7:6];
  assign numeric_oscillator_out = src[8];
  assign comparator_out = src[10:9];
  assign logic_cell_out = src[14:11];
  assign serial_one_tx = src[15];
  assign spi_data_out = src[17:16];
  assign serial_port_two_tx = src[19];
endmodule // dmod_src_model
`default_nettype wire

// ===== testbench/dmod_tb.sv
// Self-checking testbench of the data signal modulator
`include "dmod_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        clk;
  logic        rstn;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic [23:0] lvl;
  logic [23:0] tog;
  logic        mpin, lpin, hpin, fosc, rclk, nco, ser1, ser2, mout;
  logic [4:0]  ccp;
  logic [1:0]  pwm, cmp, spi;
  logic [3:0]  lc;
  int          n_fail;
  int          checked;
  logic [11:0] addrs [5] = '{`DMOD_ADDR_CON0, `DMOD_ADDR_CON1,
                             `DMOD_ADDR_SRC, `DMOD_ADDR_LCAR, `DMOD_ADDR_HCAR};
  logic [7:0]  wpat [5] = '{8'h7f, 8'hff, 8'hff, 8'hff, 8'hff};
  logic [7:0]  rexp [5] = '{8'h11, 8'h33, 8'h1f, 8'h0f, 8'h0f};

  dmod_src_model src (.clk(clk), .rstn(rstn), .lvl(lvl), .tog(tog),
    .modulator_pin_route(mpin), .low_carrier_pin_route(lpin),
    .high_carrier_pin_route(hpin), .fast_internal_oscillator(fosc),
    .reference_clock_output(rclk), .ccp_out(ccp), .pwm_out(pwm),
    .numeric_oscillator_out(nco), .comparator_out(cmp),
    .logic_cell_out(lc), .serial_one_tx(ser1), .spi_data_out(spi),
    .serial_port_two_tx(ser2));

  dmod_top dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .modulator_pin_route(mpin),
    .low_carrier_pin_route(lpin), .high_carrier_pin_route(hpin),
    .fast_internal_oscillator(fosc), .reference_clock_output(rclk),
    .ccp_out(ccp), .pwm_out(pwm), .numeric_oscillator_out(nco),
    .comparator_out(cmp), .logic_cell_out(lc), .serial_one_tx(ser1),
    .spi_data_out(spi), .serial_port_two_tx(ser2), .modulated_out(mout));

  always #4 clk = ~clk;

  task automatic test_done;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Register read; data are taken in the one cycle they stand
  task automatic chk_reg(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  // Settle covers the two extra synchroniser stages of pin sources
  task automatic chk_out(input logic exp);
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk({7'h00, mout}, {7'h00, exp});
  endtask

  task automatic set_lvl(input logic [23:0] v);
    @(posedge clk);
    lvl <= v;
  endtask

  task automatic wait_out(input logic v);
    for (int i = 0; i < 64 && mout !== v; i++) @(negedge clk);
    if (mout !== v) begin
      n_fail++;
      test_done;
    end
  endtask

  function automatic int car_idx(input int s, input int c);
    case (c)
      0: return s ? 21 : 20;
      2: return 22;
      3: return 23;
      10: return 8;
      15: return 18;
      default: return (c < 10) ? c - 2 : c;
    endcase
  endfunction

  // Toggling carrier is code 4; the other side holds a steady level on code 5
  task automatic sync_case(input logic high, input logic sync);
    set_lvl(high ? 24'h000000 : 24'h000008);
    tog <= 24'h000004;
    wr(`DMOD_ADDR_HCAR, high ? 8'h04 : 8'h05);
    wr(`DMOD_ADDR_LCAR, high ? 8'h05 : 8'h04);
    wr(`DMOD_ADDR_CON1, high ? {3'h0, sync, 4'h0} : {7'h00, sync});
    wr(`DMOD_ADDR_CON0, high ? 8'h81 : 8'h80);
    // The first edge may come from the carrier switch; the second is true
    wait_out(!high);
    wait_out(high);
    wait_out(!high);
    wait_out(high);
    wr(`DMOD_ADDR_CON0, high ? 8'h80 : 8'h81);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk({7'h00, mout}, {7'h00, high ~^ sync});
    repeat (16) @(posedge clk);
    chk_out(!high);
    @(posedge clk);
    tog <= 24'h000000;
  endtask

  initial begin
    logic b;
    clk = 1'b0;
    rstn = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    lvl = 24'h000000;
    tog = 24'h000000;
    n_fail = 0;
    checked = 0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 5; i++) chk_reg(addrs[i], 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(addrs[i], wpat[i]);
      chk_reg(addrs[i], rexp[i]);
      wr(addrs[i], 8'h00);
    end
    wr(12'h896, 8'hff);
    chk_reg(12'h896, 8'h00);
    chk_reg(12'h89c, 8'h00);
    // Modulator sources: high carrier steady 1, low carrier steady 0
    wr(`DMOD_ADDR_HCAR, 8'h03);
    wr(`DMOD_ADDR_LCAR, 8'h02);
    wr(`DMOD_ADDR_CON0, 8'h81);
    for (int c = 0; c < 20; c++) begin
      wr(`DMOD_ADDR_SRC, c[7:0]);
      if (c == 1) begin
        chk_out(1'b1);
        wr(`DMOD_ADDR_CON0, 8'h80);
        chk_out(1'b0);
        wr(`DMOD_ADDR_CON0, 8'h81);
      end else begin
        set_lvl(24'h800000 | (24'h000001 << c));
        chk_out(1'b1);
        set_lvl(24'h800000);
        chk_out(1'b0);
      end
    end
    set_lvl(24'h8fffff);
    wr(`DMOD_ADDR_SRC, 8'h14);
    chk_out(1'b0);
    wr(`DMOD_ADDR_SRC, 8'h1f);
    chk_out(1'b0);
    // Carrier maps, modulator from the software bit
    wr(`DMOD_ADDR_SRC, 8'h01);
    for (int s = 0; s < 2; s++) begin
      wr(`DMOD_ADDR_CON0, {7'h40, s[0]});
      for (int c = 0; c < 16; c++) begin
        set_lvl(24'h000000);
        wr(s ? `DMOD_ADDR_HCAR : `DMOD_ADDR_LCAR, c[7:0]);
        if (c == 1) begin
          repeat (6) @(posedge clk);
          @(negedge clk);
          b = mout;
          @(negedge clk);
          chk({7'h00, mout}, {7'h00, ~b});
        end else begin
          set_lvl(24'h000001 << car_idx(s, c));
          chk_out(1'b1);
          set_lvl(24'h000000);
          chk_out(1'b0);
        end
      end
    end
    // Polarity, status and enable
    wr(`DMOD_ADDR_HCAR, 8'h03);
    wr(`DMOD_ADDR_LCAR, 8'h02);
    set_lvl(24'h800000);
    wr(`DMOD_ADDR_CON0, 8'h81);
    chk_out(1'b1);
    wr(`DMOD_ADDR_CON1, 8'h20);
    chk_out(1'b0);
    wr(`DMOD_ADDR_CON0, 8'h80);
    wr(`DMOD_ADDR_CON1, 8'h02);
    chk_out(1'b1);
    wr(`DMOD_ADDR_CON1, 8'h00);
    wr(`DMOD_ADDR_CON0, 8'h90);
    chk_out(1'b1);
    chk_reg(`DMOD_ADDR_CON0, 8'hb0);
    wr(`DMOD_ADDR_CON0, 8'h10);
    chk_out(1'b0);
    chk_reg(`DMOD_ADDR_CON0, 8'h10);
    chk_reg(`DMOD_ADDR_SRC, 8'h01);
    chk_reg(`DMOD_ADDR_HCAR, 8'h03);
    wr(`DMOD_ADDR_CON0, 8'h90);
    chk_out(1'b1);
    // Carrier synchronisation, both sides, on and off
    sync_case(1'b1, 1'b0);
    sync_case(1'b1, 1'b1);
    sync_case(1'b0, 1'b0);
    sync_case(1'b0, 1'b1);
    test_done;
  end
endmodule // tb
`default_nettype wire
